// >>> verification/led_dim_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module led_dim_ctrl_sva #(
  parameter logic [19:0] FF_CYC = 20'd50
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        enable_i,
  input wire logic        ovp_uv_i,
  input wire logic        over_temp_i,
  input wire logic [5:0]  sink_on_o,
  input wire logic        derate_o,
  input wire logic        fault_flag_output_n_o,
  input wire logic        input_disconnect_drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [10:0] uv_cnt;  // consecutive undervoltage cycles
  logic [19:0] low_cnt; // cycles the fault output has stood low
  // count undervoltage run while enabled, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || !ovp_uv_i || !enable_i) begin
      uv_cnt <= 11'h000;
    end else if (uv_cnt != 11'h7FF) begin
      uv_cnt <= uv_cnt + 11'h001;
    end
  end
  // count length of each fault output low phase
  always_ff @(posedge clk_i) begin
    if (rst_i || fault_flag_output_n_o) begin
      low_cnt <= 20'h00000;
    end else if (low_cnt != 20'hFFFFF) begin
      low_cnt <= low_cnt + 20'h00001;
    end
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  uv_latch_a: assert property (uv_cnt >= 11'd1003 |-> input_disconnect_drive_o)
    else $error("undervoltage did not drive disconnect");
  latch_hold_a: assert property (input_disconnect_drive_o && enable_i |=> input_disconnect_drive_o)
    else $error("latch-off released while enabled");
  fault_low_a: assert property ($rose(input_disconnect_drive_o) |-> ##[0:2] !fault_flag_output_n_o)
    else $error("fault output not low on protection");
  fault_delay_a: assert property ($rose(fault_flag_output_n_o) |-> low_cnt >= FF_CYC - 20'h1)
    else $error("fault output released too early");
  sink_disable_a: assert property (!enable_i [*2] |-> sink_on_o == 6'h00)
    else $error("sinks on while disabled");
  derate_cool_a: assert property (!over_temp_i [*2] |-> !derate_o)
    else $error("derating without over temperature");
  cover property (wb_ack_o);
  cover property ($rose(input_disconnect_drive_o));
  cover property ($rose(fault_flag_output_n_o));
endmodule
`default_nettype wire

// >>> verification/led_dimming_protection_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module led_dimming_protection_ctrl_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        dim_i = 1'b0;
  logic        enable_i = 1'b0;
  logic        ovp_uv_i = 1'b0, comp_sat_i = 1'b0, over_temp_i = 1'b0;
  logic [5:0]  sink_short_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'hF, sel = 4'hF;
  logic        min_2v, derate, standby;
  logic        sw_ilim_i = 1'b0;
  logic [5:0]  open_mask = 6'h00;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, stop_switch_o, spread_en_o, spread_range_o, ff_n, sd, ovp_hit, sw_cyc;
  logic [5:0]  sink_on_o, sink_low;
  logic [7:0]  amp_o;
  logic [1:0]  spread_mod_o;
  int          fail_count = 0;
  int          total_checks = 0;
  // rows: write flag, byte address, write data, expected read
  logic [24:0] rows [13] = '{{1'b0, 8'h00, 8'h00, 8'h86}, {1'b0, 8'h04, 8'h00, 8'h28},
    {1'b0, 8'h08, 8'h00, 8'h00}, {1'b0, 8'h0C, 8'h00, 8'h5A}, {1'b0, 8'h10, 8'h00, 8'h00},
    {1'b0, 8'h18, 8'h00, 8'h00}, {1'b1, 8'h18, 8'h55, 8'h00}, {1'b0, 8'h18, 8'h00, 8'h00},
    {1'b1, 8'h04, 8'h2B, 8'h00}, {1'b0, 8'h04, 8'h00, 8'h2B}, {1'b1, 8'h08, 8'hC0, 8'h00},
    {1'b0, 8'h08, 8'h00, 8'hC0}, {1'b0, 8'h14, 8'h00, 8'h00}};
  always #5 clk_i = ~clk_i;
  led_dimming_protection_ctrl #(.FF_CYC(20'd50), .RTPER_CYC(20'd2000), .SHORT_CYC(20'd30),
    .ALLSH_CYC(26'd100), .SAT20_CYC(23'd60), .SAT40_CYC(23'd120)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dim_i(dim_i), .enable_i(enable_i),
    .ovp_hit_i(ovp_hit), .sink_low_i(sink_low), .sink_short_i(sink_short_i),
    .comp_sat_i(comp_sat_i),
    .ovp_uv_i(ovp_uv_i), .sw_ilim_i(sw_ilim_i), .sw_cycle_i(sw_cyc), .over_temp_i(over_temp_i),
    .sink_on_o(sink_on_o), .amp_o(amp_o), .min_sink_2v_o(min_2v), .ovp93_o(),
    .stop_switch_o(stop_switch_o), .spread_en_o(spread_en_o), .spread_range_o(spread_range_o),
    .spread_mod_o(spread_mod_o), .short_threshold_field_o(), .sw_freq_sel_o(), .derate_o(derate),
    .standby_o(standby), .fault_flag_output_n_o(ff_n), .input_disconnect_drive_o(sd));
  led_strings_model strings (.clk_i(clk_i), .sink_on_i(sink_on_o), .open_mask_i(open_mask),
    .sink_low_o(sink_low), .ovp_hit_o(ovp_hit), .sw_cycle_o(sw_cyc));
  // one classic cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i    <= 1'b0;
    enable_i <= 1'b1;
    foreach (rows[i]) begin
      wb(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (!rows[i][24]) chk("register", rd, {24'h0, rows[i][7:0]});
    end
    sel = 4'hE;
    wb(1'b1, 8'h04, 8'h00);
    sel = 4'hF;
    wb(1'b0, 8'h04, 8'h00);
    chk("sel ignored", rd, 32'h2B);
    $display("register table done");
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h00, {3'b101, 2'b00, m[1:0], m[0]});
      repeat (2) @(posedge clk_i);
      chk("spread mod", spread_mod_o, m[1:0]);
      chk("spread range", spread_range_o, m[0]);
      chk("spread en", spread_en_o, m != 3);
    end
    $display("spread done");
    dim_i <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, 8'h04, 8'h28 | k[7:0]);
      repeat (5) @(posedge clk_i);
      chk("channels", sink_on_o, 6'h3F >> k);
      chk("amp full", amp_o, 8'hFF);
    end
    dim_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("gated off", sink_on_o, 6'h00);
    wb(1'b1, 8'h00, 8'hC7);
    repeat (2) @(posedge clk_i);
    chk("low duty 2v", min_2v, 1'b1);
    chk("analog amp", amp_o, 8'h00);
    wb(1'b1, 8'h00, 8'hA7);
    over_temp_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("derate", derate, 1'b1);
    chk("amp derated", amp_o, 8'h7F);
    over_temp_i <= 1'b0;
    $display("pwm dimming done");
    wb(1'b1, 8'h04, 8'h28);
    dim_i     <= 1'b1;
    open_mask <= 6'h20;
    repeat (20) @(posedge clk_i);
    wb(1'b0, 8'h10, 8'h00);
    chk("marked", rd, 32'h20);
    chk("string off", sink_on_o[5], 1'b0);
    chk("fault low", ff_n, 1'b0);
    wb(1'b0, 8'h08, 8'h00);
    chk("open bit", rd[0], 1'b1);
    open_mask <= 6'h00;
    repeat (3000) @(posedge clk_i);
    wb(1'b0, 8'h10, 8'h00);
    chk("restored", rd, 32'h00);
    repeat (70) @(posedge clk_i);
    chk("fault released", ff_n, 1'b1);
    $display("open string done");
    sink_short_i <= 6'h01;
    repeat (110) @(posedge clk_i);
    chk("standby", standby, 1'b1);
    wb(1'b0, 8'h10, 8'h00);
    chk("short marked", rd, 32'h01);
    sink_short_i <= 6'h00;
    repeat (2) @(posedge clk_i);
    chk("standby left", standby, 1'b0);
    sw_ilim_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    sw_ilim_i <= 1'b0;
    wb(1'b0, 8'h08, 8'h00);
    chk("oc bit", rd[2], 1'b1);
    chk("latched stop", stop_switch_o, 1'b1);
    wb(1'b0, 8'h08, 8'h00);
    chk("oc cleared", rd[2], 1'b0);
    ovp_uv_i <= 1'b1;
    repeat (1010) @(posedge clk_i);
    chk("disconnect", sd, 1'b1);
    ovp_uv_i <= 1'b0;
    wb(1'b0, 8'h08, 8'h00);
    chk("uv bit", rd[3], 1'b1);
    enable_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("unlatched", sd, 1'b0);
    enable_i <= 1'b1;
    comp_sat_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("sat pending", sd, 1'b0);
    repeat (25) @(posedge clk_i);
    chk("sat disconnect", sd, 1'b1);
    chk("sat fault", ff_n, 1'b0);
    comp_sat_i <= 1'b0;
    $display("latch-off done");
    report_and_stop();
  end
endmodule
bind led_dimming_protection_ctrl led_dim_ctrl_sva #(.FF_CYC(FF_CYC)) chk_i (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .enable_i(enable_i), .ovp_uv_i(ovp_uv_i), .over_temp_i(over_temp_i),
  .sink_on_o(sink_on_o), .derate_o(derate_o), .fault_flag_output_n_o(fault_flag_output_n_o),
  .input_disconnect_drive_o(input_disconnect_drive_o));
`default_nettype wire

// >>> verification/led_strings_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_strings_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] sink_on_i,
  input  wire logic [5:0] open_mask_i,
  output logic      [5:0] sink_low_o,
  output logic            ovp_hit_o,
  output logic            sw_cycle_o
);
  logic [2:0] cyc_cnt = 3'h0; // switching period divider
  // open strings pull their sink pin low
  assign sink_low_o = open_mask_i;
  // boost stage: cycle pulse every 8 clocks, overvoltage when an open string is lit
  always_ff @(posedge clk_i) begin
    cyc_cnt    <= cyc_cnt + 3'h1;
    sw_cycle_o <= (cyc_cnt == 3'h7);
    ovp_hit_o  <= |(sink_on_i & open_mask_i);
  end
endmodule
`default_nettype wire

// >>> verilog/led_dim_consts.svh
`ifndef LED_DIM_CONSTS_SVH
`define LED_DIM_CONSTS_SVH
// clock period
`define CLK_NS 10
// register indexes, byte address is index times four
`define IDX_FN1 3'h0
`define IDX_FN2 3'h1
`define IDX_FLT 3'h2
`define IDX_ID 3'h3
`define IDX_MARK 3'h4
`define IDX_DUTY 3'h5
`define IDX_LAST 3'h5
// reset values
`define RST_FN1 8'h86
`define RST_FN2 8'h28
`define ID_VALUE 8'h5A
// field positions, function set 1
`define B_THERMAL_DERATE_ENABLE 7
`define B_MODE 5
`define B_MIX_TRANSFER_POINT_BIT 4
`define B_MIXFR 3
`define B_FSPMF 1
`define B_SPREAD_RANGE_BIT 0
// field positions, function set 2
`define B_PSE 7
`define B_THS 5
`define B_FSW 3
`define B_CH 0
// field positions, fault register
`define B_SEN 7
`define B_SATURATION_TIME_SELECT 6
// duty and amplitude codes on a 256 scale
`define DUTY_TP25 8'h40
`define DUTY_TP125 8'h20
`define DUTY_10PCT 8'h1A
`define AMP_FULL 8'hFF
`define AMP_QTR 8'h40
// times in ns, then the current-limit cycle count
`define T_US_NS 1000
`define T_MIX200_NS 19531
`define T_MIX23K_NS 170
`define T_ON7_NS 7000
`define T_FF_NS 750000
`define T_RTPER_NS 500000
`define T_RTPUL_NS 10000
`define T_SHORT_NS 7700000
`define T_ALLSH_NS 480000000
`define T_SAT20_NS 20000000
`define T_SAT40_NS 40000000
`define T_UV_NS 10000
`define OC_CYCLES 3'h5
`endif

// >>> verilog/led_dim_pkg.sv
package led_dim_pkg;
  // resolved dimming method
  typedef enum logic [2:0] {
    D_MIX = 3'b001,
    D_PWM = 3'b010,
    D_ANA = 3'b100
  } dim_sel_t;
endpackage

// >>> verilog/led_dimming_protection_ctrl.sv
// Functional notes
// - mix: analog above point, quarter amplitude below
// - transfer point bit: 25% clear, 12.5% set
// - mode 00 selects mix dimming
// - mix output rate set only by bit
// - mode 01 selects direct PWM dimming
// - direct PWM: full amplitude gated by input
// - mode 10 selects analog dimming
// - analog: amplitude equals measured input duty
// - analog duty below 10%: raise sink target
// - on-time under 7us: regulate 0.93 overvoltage
// - channel count field enables lowest channels
// - phase shift bit enables shifted sinks
// - each channel lags by 360 over count
// - spread range bit: 1/20 or 1/32
// - spread modulation field sets rate or off
// - fault low on trigger, release 750us later
// - fault bits sticky, cleared on read
// - overvoltage: stop, mark strings under 100mV
// - marked strings retested 10us every 500us
// - short held 7.7ms marks string off
// - short held 480ms: all off, standby
// - compensation saturated 20/40ms: disconnect, latch
// - output under threshold 10us: disconnect, latch
// - current limit five cycles running: latch
// - hot die derates amplitude when enabled
`timescale 1ns/1ps
`default_nettype none
`include "led_dim_consts.svh"
module led_dimming_protection_ctrl
  import led_dim_pkg::*;
#(
  parameter logic [19:0] FF_CYC    = 20'(`T_FF_NS / `CLK_NS),
  parameter logic [19:0] RTPER_CYC = 20'(`T_RTPER_NS / `CLK_NS),
  parameter logic [19:0] SHORT_CYC = 20'(`T_SHORT_NS / `CLK_NS),
  parameter logic [25:0] ALLSH_CYC = 26'(`T_ALLSH_NS / `CLK_NS),
  parameter logic [22:0] SAT20_CYC = 23'(`T_SAT20_NS / `CLK_NS),
  parameter logic [22:0] SAT40_CYC = 23'(`T_SAT40_NS / `CLK_NS)
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        dim_i,
  input  wire logic        enable_i,
  input  wire logic        ovp_hit_i,
  input  wire logic [5:0]  sink_low_i,
  input  wire logic [5:0]  sink_short_i,
  input  wire logic        comp_sat_i,
  input  wire logic        ovp_uv_i,
  input  wire logic        sw_ilim_i,
  input  wire logic        sw_cycle_i,
  input  wire logic        over_temp_i,
  output logic      [5:0]  sink_on_o,
  output logic      [7:0]  amp_o,
  output logic             min_sink_2v_o,
  output logic             ovp93_o,
  output logic             stop_switch_o,
  output logic             spread_en_o,
  output logic             spread_range_o,
  output logic      [1:0]  spread_mod_o,
  output logic      [1:0]  short_threshold_field_o,
  output logic      [1:0]  sw_freq_sel_o,
  output logic             derate_o,
  output logic             standby_o,
  output logic             fault_flag_output_n_o,
  output logic             input_disconnect_drive_o
);
  localparam logic [6:0]  US_CYC   = 7'(`T_US_NS / `CLK_NS);
  localparam logic [10:0] MIXS_LO  = 11'(`T_MIX200_NS / `CLK_NS);
  localparam logic [10:0] MIXS_HI  = 11'(`T_MIX23K_NS / `CLK_NS);
  localparam logic [19:0] ON7_CYC  = 20'((`T_ON7_NS + `CLK_NS - 1) / `CLK_NS);
  localparam logic [19:0] RTPUL_CYC = 20'(`T_RTPUL_NS / `CLK_NS);
  localparam logic [9:0]  UV_CYC   = 10'(`T_UV_NS / `CLK_NS);

  // configuration and status registers
  logic [7:0] cfg1;          // function set 1
  logic [7:0] cfg2;          // function set 2
  logic [1:0] cfg3;          // all-short enable, saturation select
  logic [5:0] fault_bits;    // sticky fault indications
  logic [7:0] duty;          // measured input duty, 256 scale

  // field decode
  wire       thermal_derate_enable  = cfg1[`B_THERMAL_DERATE_ENABLE];
  wire [1:0] dimming_mode_field     = cfg1[`B_MODE +: 2];
  wire       mix_transfer_point_bit = cfg1[`B_MIX_TRANSFER_POINT_BIT];
  wire       mix_freq_bit           = cfg1[`B_MIXFR];
  wire [1:0] spread_modulation_field = cfg1[`B_FSPMF +: 2];
  wire       spread_range_bit       = cfg1[`B_SPREAD_RANGE_BIT];
  wire       phase_shift_enable     = cfg2[`B_PSE];
  wire [2:0] channel_count_field    = cfg2[`B_CH +: 3];
  wire       all_short_enable       = cfg3[1];
  wire       saturation_time_select = cfg3[0];

  // bus decode
  wire       bus_req  = wb_cyc_i & wb_stb_i;
  wire       bus_take = bus_req & wb_ack_o;
  wire [2:0] bus_idx  = wb_adr_i[4:2];
  wire       bus_hit  = (wb_adr_i[7:5] == 3'h0) & (bus_idx <= `IDX_LAST);
  wire       bus_wr   = bus_take & bus_hit & wb_we_i & wb_sel_i[0];
  wire       flt_rd   = bus_take & bus_hit & ~wb_we_i & (bus_idx == `IDX_FLT);

  // protection state
  logic       latched;       // latch-off held
  logic       disc;          // input disconnect drive
  wire  [5:0] marked;        // strings marked off
  wire  [5:0] open_ev;       // open marking events
  wire  [5:0] short_ev;      // short marking events

  // read data selection
  wire [7:0] rd_byte =
    (bus_idx == `IDX_FN1)  ? cfg1 :
    (bus_idx == `IDX_FN2)  ? cfg2 :
    (bus_idx == `IDX_FLT)  ? {cfg3, fault_bits} :
    (bus_idx == `IDX_ID)   ? `ID_VALUE :
    (bus_idx == `IDX_MARK) ? {2'h0, marked} :
    duty;
  wire [7:0] rd_sel = bus_hit ? rd_byte : 8'h00;

  // ack one cycle after request, read data latched with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req & ~wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rd_sel};
      end
    end
  end

  // register writes at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg1 <= `RST_FN1;
      cfg2 <= `RST_FN2;
      cfg3 <= 2'h0;
    end else if (bus_wr) begin
      if (bus_idx == `IDX_FN1) begin
        cfg1 <= wb_dat_i[7:0];
      end
      if (bus_idx == `IDX_FN2) begin
        cfg2 <= wb_dat_i[7:0];
      end
      if (bus_idx == `IDX_FLT) begin
        cfg3 <= wb_dat_i[7:6];
      end
    end
  end

  // microsecond tick
  logic [6:0] us_cnt;
  wire        us_tick = (us_cnt == US_CYC - 7'h01);
  always_ff @(posedge clk_i) begin
    if (rst_i || us_tick) begin
      us_cnt <= 7'h00;
    end else begin
      us_cnt <= us_cnt + 7'h01;
    end
  end

  // duty measurement over a 16384 us window
  logic [13:0] win_cnt;      // window position
  logic [13:0] hi_cnt;       // high samples in window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt <= 14'h0000;
      hi_cnt  <= 14'h0000;
      duty    <= 8'h00;
    end else if (us_tick) begin
      win_cnt <= win_cnt + 14'h0001;
      if (win_cnt == 14'h3FFF) begin
        duty   <= hi_cnt[13:6];
        hi_cnt <= {13'h0000, dim_i};
      end else begin
        hi_cnt <= hi_cnt + {13'h0000, dim_i};
      end
    end
  end

  // internal mix pwm, rate from the frequency bit only
  logic [10:0] mix_div;      // step divider
  logic [7:0]  mix_ph;       // phase within mix period
  wire  [10:0] mix_step = mix_freq_bit ? MIXS_HI : MIXS_LO;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mix_div <= 11'h000;
      mix_ph  <= 8'h00;
    end else if (mix_div >= mix_step - 11'h001) begin
      mix_div <= 11'h000;
      mix_ph  <= mix_ph + 8'h01;
    end else begin
      mix_div <= mix_div + 11'h001;
    end
  end
  wire mix_on = {2'h0, mix_ph} < {duty, 2'h0};

  // dimming method
  dim_sel_t dsel;
  always_comb begin
    unique case (dimming_mode_field)
      2'b01:   dsel = D_PWM;
      2'b10:   dsel = D_ANA;
      default: dsel = D_MIX;
    endcase
  end

  wire [7:0] tp      = mix_transfer_point_bit ? `DUTY_TP125 : `DUTY_TP25;
  wire       low_mix = duty < tp;
  logic      gate;           // common dimming gate
  logic [7:0] amp_raw;       // amplitude before derating
  always_comb begin
    unique case (dsel)
      D_MIX: begin
        gate    = low_mix ? mix_on : 1'b1;
        amp_raw = low_mix ? `AMP_QTR : duty;
      end
      D_PWM: begin
        gate    = dim_i;
        amp_raw = `AMP_FULL;
      end
      D_ANA: begin
        gate    = 1'b1;
        amp_raw = duty;
      end
    endcase
  end
  wire derate = thermal_derate_enable & over_temp_i;
  wire [7:0] amp_next = derate ? {1'b0, amp_raw[7:1]} : amp_raw;

  // gate on-time and period measurement
  logic        gate_q;       // gate one cycle ago
  logic [19:0] on_cnt;       // current on-time
  logic [19:0] on_len;       // last on-time
  logic [19:0] per_cnt;      // position since last rise
  logic [19:0] per_len;      // last period
  wire         gate_rise = gate & ~gate_q;
  wire         gate_fall = ~gate & gate_q;
  wire         per_sat   = &per_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q  <= 1'b0;
      on_cnt  <= 20'h00000;
      on_len  <= 20'h00000;
      per_cnt <= 20'hFFFFF;
      per_len <= 20'h00001;
      ovp93_o <= 1'b0;
    end else begin
      gate_q <= gate;
      if (gate_rise) begin
        on_cnt  <= 20'h00001;
        per_cnt <= 20'h00000;
        if (!per_sat) begin
          per_len <= per_cnt + 20'h00001;
        end
      end else begin
        if (gate && !(&on_cnt)) begin
          on_cnt <= on_cnt + 20'h00001;
        end
        if (!per_sat) begin
          per_cnt <= per_cnt + 20'h00001;
        end
      end
      if (gate_fall) begin
        on_len  <= on_cnt;
        ovp93_o <= on_cnt < ON7_CYC;
      end else if (gate && on_cnt >= ON7_CYC) begin
        ovp93_o <= 1'b0;
      end
    end
  end

  // active channel count and phase step
  wire [2:0] n_act = (channel_count_field > 3'h5) ? 3'h1 :
                     3'h6 - channel_count_field;
  logic [16:0] recip;        // 65536 over channel count
  always_comb begin
    unique case (n_act)
      3'h2:    recip = 17'h08000;
      3'h3:    recip = 17'h05556;
      3'h4:    recip = 17'h04000;
      3'h5:    recip = 17'h0333A;
      3'h6:    recip = 17'h02AAB;
      default: recip = 17'h10000;
    endcase
  end
  wire [36:0] step_prod = {17'h00000, per_len} * {20'h00000, recip};
  wire [19:0] step      = step_prod[35:16];

  // retest timer: period then pulse
  logic [19:0] rt_cnt;
  wire         rt_on  = rt_cnt >= RTPER_CYC;
  wire         rt_end = rt_cnt == RTPER_CYC + RTPUL_CYC - 20'h00001;
  always_ff @(posedge clk_i) begin
    if (rst_i || rt_end) begin
      rt_cnt <= 20'h00000;
    end else begin
      rt_cnt <= rt_cnt + 20'h00001;
    end
  end

  // per-channel sink, marking and short timing
  wire [5:0] ch_gate;
  wire [5:0] ch_en;
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_ch
      logic [19:0] sc;       // short persistence count
      logic        mark_q;   // string marked off
      wire  [19:0] off = 20'(step * 20'(i));
      wire  [19:0] dpos = (per_cnt >= off) ? per_cnt - off :
                          per_cnt + per_len - off;
      wire         ph_on = per_sat ? gate : (dpos < on_len);
      assign ch_en[i]   = 3'(i) < n_act;
      if (i == 0) begin : g_first
        assign ch_gate[i] = gate;
      end else begin : g_rest
        assign ch_gate[i] = phase_shift_enable ? ph_on : gate;
      end
      assign open_ev[i]  = ovp_hit_i & sink_low_i[i] & ch_en[i] & ~mark_q;
      assign short_ev[i] = (sc == SHORT_CYC - 20'h00001) & ~mark_q;
      assign marked[i]   = mark_q;
      // short counter, runs only while lit and above threshold
      always_ff @(posedge clk_i) begin
        if (rst_i || !sink_short_i[i] || !ch_en[i] || mark_q) begin
          sc <= 20'h00000;
        end else if (gate && sc != SHORT_CYC - 20'h00001) begin
          sc <= sc + 20'h00001;
        end
      end
      // mark set by faults, cleared after a clean retest
      always_ff @(posedge clk_i) begin
        if (rst_i || !ch_en[i]) begin
          mark_q <= 1'b0;
        end else if (open_ev[i] || short_ev[i]) begin
          mark_q <= 1'b1;
        end else if (rt_end && !sink_low_i[i] && !sink_short_i[i]) begin
          mark_q <= 1'b0;
        end
      end
    end
  endgenerate

  // all-string short timing and standby
  logic [25:0] as_cnt;
  wire any_short = |(sink_short_i & ch_en);
  always_ff @(posedge clk_i) begin
    if (rst_i || !any_short || !all_short_enable) begin
      as_cnt <= 26'h0000000;
    end else if (gate && as_cnt != ALLSH_CYC) begin
      as_cnt <= as_cnt + 26'h0000001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !any_short) begin
      standby_o <= 1'b0;
    end else if (as_cnt == ALLSH_CYC) begin
      standby_o <= 1'b1;
    end
  end

  // compensation saturation timing
  logic [22:0] sat_cnt;
  wire  [22:0] sat_lim = saturation_time_select ? SAT40_CYC : SAT20_CYC;
  wire         sat_ev  = sat_cnt == sat_lim - 23'h000001;
  // holds at the limit, so a part already latched still disconnects
  always_ff @(posedge clk_i) begin
    if (rst_i || !comp_sat_i) begin
      sat_cnt <= 23'h000000;
    end else if (!sat_ev) begin
      sat_cnt <= sat_cnt + 23'h000001;
    end
  end

  // output under-voltage timing
  logic [9:0] uv_cnt;
  wire        uv_ev = uv_cnt == UV_CYC - 10'h001;
  // holds at the limit, so a part already latched still disconnects
  always_ff @(posedge clk_i) begin
    if (rst_i || !ovp_uv_i) begin
      uv_cnt <= 10'h000;
    end else if (!uv_ev) begin
      uv_cnt <= uv_cnt + 10'h001;
    end
  end

  // consecutive current-limit cycles
  logic       ilim_seen;     // limit hit in this cycle
  logic [2:0] oc_run;        // cycles in a row
  wire        ilim_cyc = ilim_seen | sw_ilim_i;
  wire        oc_ev = sw_cycle_i & ilim_cyc & (oc_run == `OC_CYCLES - 3'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ilim_seen <= 1'b0;
      oc_run    <= 3'h0;
    end else if (sw_cycle_i) begin
      ilim_seen <= 1'b0;
      oc_run    <= ilim_cyc ? oc_run + 3'h1 : 3'h0;
    end else begin
      ilim_seen <= ilim_cyc;
    end
  end

  // latch-off, held until disable
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      latched <= 1'b0;
      disc    <= 1'b0;
    end else begin
      if (sat_ev || uv_ev || oc_ev) begin
        latched <= 1'b1;
      end
      if (sat_ev || uv_ev) begin
        disc <= 1'b1;
      end
    end
  end

  // sticky fault bits, only reported bits clear, a new event wins
  wire [5:0] flt_ev = {sat_ev, over_temp_i, uv_ev, oc_ev, |short_ev, |open_ev};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_bits <= 6'h00;
    end else begin
      fault_bits <= (fault_bits & ~({6{flt_rd}} & wb_dat_o[5:0])) | flt_ev;
    end
  end

  // fault output, released after the hold delay
  logic [19:0] ff_cnt;
  wire prot = latched | standby_o | (|marked) | over_temp_i | (|flt_ev);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_flag_output_n_o <= 1'b1;
      ff_cnt                <= 20'h00000;
    end else if (prot) begin
      fault_flag_output_n_o <= 1'b0;
      ff_cnt                <= 20'h00000;
    end else if (!fault_flag_output_n_o) begin
      if (ff_cnt == FF_CYC - 20'h00001) begin
        fault_flag_output_n_o <= 1'b1;
      end else begin
        ff_cnt <= ff_cnt + 20'h00001;
      end
    end
  end

  // sink drive: enabled, unmarked, or pulsed for retest
  wire run = enable_i & ~latched & ~standby_o;
  wire [5:0] next_sink = {6{run}} & ch_en &
                         ((~marked & ch_gate) | (marked & {6{rt_on}}));

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sink_on_o                <= 6'h00;
      amp_o                    <= 8'h00;
      min_sink_2v_o            <= 1'b0;
      stop_switch_o            <= 1'b1;
      spread_en_o              <= 1'b0;
      spread_range_o           <= 1'b0;
      spread_mod_o             <= 2'h3;
      short_threshold_field_o  <= 2'h1;
      sw_freq_sel_o            <= 2'h1;
      derate_o                 <= 1'b0;
      input_disconnect_drive_o <= 1'b0;
    end else begin
      sink_on_o                <= next_sink;
      amp_o                    <= amp_next;
      min_sink_2v_o            <= (dsel == D_ANA) & (duty < `DUTY_10PCT);
      stop_switch_o            <= ovp_hit_i | ~run;
      spread_en_o              <= spread_modulation_field != 2'h3;
      spread_range_o           <= spread_range_bit;
      spread_mod_o             <= spread_modulation_field;
      short_threshold_field_o  <= cfg2[`B_THS +: 2];
      sw_freq_sel_o            <= cfg2[`B_FSW +: 2];
      derate_o                 <= derate;
      input_disconnect_drive_o <= disc;
    end
  end
endmodule
`default_nettype wire
